//--- core/oc_pkg.sv
/*
  Package for the output compare / PWM channel: register indices, control
  field positions, reset values and mode encodings.
  Assumes a 16-bit register port with one-cycle read latency.
*/
package oc_pkg;

  // ----------------------------------------------------------------
  // register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_PRIMARY = 3'h1;
  localparam logic [2:0] ADDR_SECONDARY = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;

  // ----------------------------------------------------------------
  // control and status register fields
  // ----------------------------------------------------------------
  localparam int CTL_IDLE_BIT = 13;
  localparam int CTL_FAULT_BIT = 4;
  localparam int CTL_TSEL_BIT = 3;
  localparam int CTL_MODE_LSB = 0;
  localparam int STAT_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and the zero count
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_COMPARE = 16'h0000;
  localparam logic [2:0] RESET_MODE = 3'h0;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_SET_HIGH = 3'h1,
    MODE_SET_LOW = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_SINGLE = 3'h4,
    MODE_CONT = 3'h5,
    MODE_PWM = 3'h6,
    MODE_PWM_FAULT = 3'h7
  } mode_t;

  // channel number governed by the second fault input
  localparam int FAULT_B_CHANNEL = 5;

endpackage

//--- core/oc_sync.sv
/*
  Two flip-flop synchroniser for one asynchronous level.
  Assumes clk shared with the caller; it has no clock enable and samples every cycle.
*/
module oc_sync
  import oc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

//--- core/output_compare_pwm_channel.sv
/*
  One output compare / PWM channel with its register port.
  Compares the selected time base against primary and secondary
  compare values and drives one output pin. The two time bases and their
  period values come from timer logic on the same clock; the fault inputs
  and idle request arrive from outside and are synchronised here.
*/
// Added by the designer: the register addresses and the strobed register port.
module output_compare_pwm_channel
  import oc_pkg::*;
#(
  parameter int CHANNEL = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // time bases from the timers, same clock
  input wire logic [15:0] timer2_count,
  input wire logic [15:0] timer2_period,
  input wire logic [15:0] timer3_count,
  input wire logic [15:0] timer3_period,
  // asynchronous inputs
  input wire logic cpu_idle,
  input wire logic fault_input_a,
  input wire logic fault_input_b,
  // outputs
  output logic compare_output_pin,
  output logic compare_interrupt_flag
);

  // ----------------------------------------------------------------
  // state and control
  // ----------------------------------------------------------------
  logic [15:0] primary_compare_value_q;
  logic [15:0] secondary_compare_value_q;
  mode_t compare_mode_field_q;
  logic time_base_select_q;
  logic stop_in_idle_q;
  logic fault_status_q;
  logic pin_q;
  logic flag_q;
  logic pulse_done_q;
  logic [15:0] rdata_q;
  logic idle_s;
  logic fault_a_s;
  logic fault_b_s;

  // ----------------------------------------------------------------
  // synchronisers for pin-side levels
  // ----------------------------------------------------------------
  oc_sync u_sync_idle (
    .clk(clk),
    .rst_n(rst_n),
    .d(cpu_idle),
    .q(idle_s)
  );

  oc_sync u_sync_fa (
    .clk(clk),
    .rst_n(rst_n),
    .d(fault_input_a),
    .q(fault_a_s)
  );

  oc_sync u_sync_fb (
    .clk(clk),
    .rst_n(rst_n),
    .d(fault_input_b),
    .q(fault_b_s)
  );

  // ----------------------------------------------------------------
  // time base selection and compare events
  // ----------------------------------------------------------------
  logic [15:0] time_base_count;
  logic [15:0] time_base_period;
  logic run;
  logic is_pwm;
  logic match_pri;
  logic match_sec;
  logic match_per;
  logic match_duty;
  logic fault_in;
  logic ctl_write;

  // third timer when select is one, else second
  assign time_base_count = time_base_select_q ? timer3_count : timer2_count;
  assign time_base_period = time_base_select_q ? timer3_period : timer2_period;
  // halt while idle if requested
  assign run = clk_en && !(stop_in_idle_q && idle_s);
  assign is_pwm = (compare_mode_field_q == MODE_PWM) || (compare_mode_field_q == MODE_PWM_FAULT);
  assign match_pri = time_base_count == primary_compare_value_q;
  assign match_sec = time_base_count == secondary_compare_value_q;
  // the timer wraps to zero after this count, so a cycle is period + 1 counts
  assign match_per = time_base_count == time_base_period;
  // the pin is registered, so the PWM fall is taken one count early to keep
  // exactly duty high counts; 17 bits keep the top count from wrapping to zero
  assign match_duty = ({1'b0, time_base_count} + 17'h00001)
                      == {1'b0, primary_compare_value_q};
  // channel five listens to the second fault input, the rest to the first
  assign fault_in = (CHANNEL == FAULT_B_CHANNEL) ? fault_b_s : fault_a_s;
  assign ctl_write = reg_write && (reg_addr == ADDR_CONTROL);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // mode, timer select and idle bits are software writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_mode_field_q <= MODE_OFF;
      time_base_select_q <= 1'b0;
      stop_in_idle_q <= 1'b0;
    end else if (clk_en && ctl_write) begin
      compare_mode_field_q <= mode_t'(reg_wdata[CTL_MODE_LSB +: 3]);
      time_base_select_q <= reg_wdata[CTL_TSEL_BIT];
      stop_in_idle_q <= reg_wdata[CTL_IDLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // compare values
  // ----------------------------------------------------------------
  // primary is latched from secondary at period match in PWM modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_compare_value_q <= RESET_COMPARE;
    end else if (clk_en) begin
      if (run && is_pwm && match_per) begin
        primary_compare_value_q <= secondary_compare_value_q;
      end else if (reg_write && reg_addr == ADDR_PRIMARY && !is_pwm) begin
        // writes are dropped while PWM runs; the pin stays low until the first period match loads secondary
        primary_compare_value_q <= reg_wdata;
      end
    end
  end

  // secondary may be written at any time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_compare_value_q <= RESET_COMPARE;
    end else if (clk_en && reg_write && reg_addr == ADDR_SECONDARY) begin
      secondary_compare_value_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // fault status
  // ----------------------------------------------------------------
  // set on fault in mode 111; cleared by hardware on leaving PWM-fault mode while no fault is present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_status_q <= 1'b0;
    end else if (clk_en) begin
      if (compare_mode_field_q == MODE_PWM_FAULT && fault_in) begin
        fault_status_q <= 1'b1;
      end else if (ctl_write && reg_wdata[CTL_MODE_LSB +: 3] != MODE_PWM_FAULT) begin
        fault_status_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  // mode write initialises the pin, then compare events move it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      pulse_done_q <= 1'b0;
    end else if (clk_en) begin
      if (ctl_write) begin
        pulse_done_q <= 1'b0;
        case (reg_wdata[CTL_MODE_LSB +: 3])
          MODE_SET_LOW: pin_q <= 1'b1;
          default: pin_q <= 1'b0;
        endcase
      end else if (run) begin
        case (compare_mode_field_q)
          MODE_OFF: begin
            pin_q <= 1'b0;
          end
          MODE_SET_HIGH: begin
            if (match_pri) pin_q <= 1'b1;
          end
          MODE_SET_LOW: begin
            if (match_pri) pin_q <= 1'b0;
          end
          MODE_TOGGLE: begin
            if (match_pri) pin_q <= !pin_q;
          end
          MODE_SINGLE: begin
            if (!pulse_done_q) begin
              if (pin_q && match_sec) begin
                pin_q <= 1'b0;
                pulse_done_q <= 1'b1;
              end else if (match_pri) begin
                pin_q <= 1'b1;
              end
            end
          end
          MODE_CONT: begin
            if (pin_q && match_sec) begin
              pin_q <= 1'b0;
            end else if (match_pri) begin
              pin_q <= 1'b1;
            end
          end
          MODE_PWM, MODE_PWM_FAULT: begin
            if (compare_mode_field_q == MODE_PWM_FAULT && (fault_in || fault_status_q)) begin
              pin_q <= 1'b0;
            end else if (match_per) begin
              // next count is zero: high unless next duty is zero
              pin_q <= (secondary_compare_value_q != COUNT_ZERO);
            end else if (match_duty) begin
              // duty above period never matches and stays high
              pin_q <= 1'b0;
            end
          end
          default: begin
            pin_q <= pin_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt event flag
  // ----------------------------------------------------------------
  // sticky; set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (run && match_sec && pin_q
          && (compare_mode_field_q == MODE_CONT
              || (compare_mode_field_q == MODE_SINGLE && !pulse_done_q))) begin
        flag_q <= 1'b1;
      end else if (run && is_pwm && match_per) begin
        flag_q <= 1'b1;
      end else if (run && (compare_mode_field_q == MODE_SET_HIGH
                           || compare_mode_field_q == MODE_SET_LOW
                           || compare_mode_field_q == MODE_TOGGLE) && match_pri) begin
        flag_q <= 1'b1;
      end else if (compare_mode_field_q == MODE_PWM_FAULT && fault_in) begin
        flag_q <= 1'b1;
      end else if (reg_write && reg_addr == ADDR_STATUS && reg_wdata[STAT_FLAG_BIT]) begin
        flag_q <= 1'b0; // write one to clear
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // data stand in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RESET_COMPARE;
    end else if (clk_en) begin
      rdata_q <= 16'h0000;
      if (reg_read) begin
        if (reg_addr == ADDR_CONTROL) begin
          rdata_q[CTL_IDLE_BIT] <= stop_in_idle_q;
          rdata_q[CTL_FAULT_BIT] <= fault_status_q;
          rdata_q[CTL_TSEL_BIT] <= time_base_select_q;
          rdata_q[CTL_MODE_LSB +: 3] <= compare_mode_field_q;
        end else if (reg_addr == ADDR_PRIMARY) begin
          rdata_q <= primary_compare_value_q;
        end else if (reg_addr == ADDR_SECONDARY) begin
          rdata_q <= secondary_compare_value_q;
        end else if (reg_addr == ADDR_STATUS) begin
          rdata_q[STAT_FLAG_BIT] <= flag_q;
        end
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign compare_output_pin = pin_q;
  assign compare_interrupt_flag = flag_q;

endmodule

//--- bench/oc_far_side.sv
/*
  Far side model: the two time bases and the fault pin levels.
  Assumes the channel samples the counts on the same rising clk edge.
*/
module oc_far_side (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] period2,
  input wire logic [15:0] period3,
  input wire logic [1:0] fault_req,
  output logic [15:0] count2,
  output logic [15:0] count3,
  output logic fault_a,
  output logic fault_b
);
  // ----------------------------------------
  // time bases
  // ----------------------------------------
  // count only while run is set, wrap to zero at the period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count2 <= 16'h0000;
      count3 <= 16'h0000;
    end else if (run) begin
      count2 <= (count2 == period2) ? 16'h0000 : count2 + 16'h0001;
      count3 <= (count3 == period3) ? 16'h0000 : count3 + 16'h0001;
    end
  end
  // fault levels, active high
  assign fault_a = fault_req[0];
  assign fault_b = fault_req[1];
endmodule

//--- bench/oc_checker.sv
/*
  Port assertions for the compare channel.
  Assumes one clk domain with asynchronous active low rst_n.
*/
module oc_checker
  import oc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [15:0] timer2_count,
  input wire logic [15:0] timer2_period,
  input wire logic [15:0] timer3_count,
  input wire logic [15:0] timer3_period,
  input wire logic fault_input_a,
  input wire logic compare_output_pin,
  input wire logic compare_interrupt_flag
);
  logic wr_ctl, tsel_q, pin, flag;
  logic [2:0] mode_q;
  logic [15:0] prim_q, sec_q, cnt, per;
  // ----------------------------------------
  // shadow registers
  // ----------------------------------------
  assign wr_ctl = clk_en && reg_write && reg_addr == ADDR_CONTROL;
  assign cnt = tsel_q ? timer3_count : timer2_count;
  assign per = tsel_q ? timer3_period : timer2_period;
  assign pin = compare_output_pin;
  assign flag = compare_interrupt_flag;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= RESET_MODE;
      tsel_q <= 1'b0;
      prim_q <= RESET_COMPARE;
      sec_q <= RESET_COMPARE;
    end else if (clk_en && reg_write) begin
      if (reg_addr == ADDR_CONTROL) begin
        mode_q <= reg_wdata[2:0];
        tsel_q <= reg_wdata[CTL_TSEL_BIT];
      end
      if (reg_addr == ADDR_PRIMARY && !(mode_q[2] && mode_q[1]))
        prim_q <= reg_wdata;
      if (reg_addr == ADDR_SECONDARY)
        sec_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_init_low: assert property (wr_ctl && reg_wdata[2:0] inside {3'h1, 3'h4, 3'h5}
    |=> !pin) else $error("pin not low after mode write");
  chk_init_high: assert property (wr_ctl && reg_wdata[2:0] == 3'h2 |=> pin)
    else $error("pin not high after mode write");
  chk_off_low: assert property (clk_en && mode_q == MODE_OFF && !wr_ctl |=> !pin)
    else $error("pin high while disabled");
  chk_cont_lead: assert property (clk_en && mode_q == MODE_CONT && !wr_ctl && cnt == prim_q
    && cnt != sec_q |=> pin) else $error("no leading edge");
  chk_cont_trail: assert property (clk_en && mode_q == MODE_CONT && !wr_ctl && pin
    && cnt == sec_q && cnt != prim_q |=> !pin && flag) else $error("no trailing edge");
  chk_single_hold: assert property (clk_en && mode_q == MODE_SINGLE && $past(pin) && !pin
    && !$past(wr_ctl) && !wr_ctl |=> !pin) else $error("second single pulse");
  chk_pwm_start: assert property (clk_en && mode_q == MODE_PWM && !wr_ctl && cnt == per
    |=> pin == ($past(sec_q) != 16'h0000)) else $error("bad pin at period start");
  chk_fault_trip: assert property ((clk_en && mode_q == MODE_PWM_FAULT && fault_input_a
    && !wr_ctl)[*4] |=> !pin && flag) else $error("fault did not stop pin");
endmodule

bind output_compare_pwm_channel oc_checker u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .timer2_count(timer2_count), .timer2_period(timer2_period), .timer3_count(timer3_count),
  .timer3_period(timer3_period), .fault_input_a(fault_input_a),
  .compare_output_pin(compare_output_pin), .compare_interrupt_flag(compare_interrupt_flag));

//--- bench/output_compare_pwm_channel_tb.sv
/*
  Bench top: register port driver, expected-value queue and monitor.
  Assumes oc_far_side supplies the time bases and fault levels.
*/
module output_compare_pwm_channel_tb
  import oc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, cpu_idle = 1'b0;
  logic run = 1'b0, rd_v = 1'b0, pin, flag, fault_a, fault_b;
  logic [1:0] fault_req = 2'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, p2 = 16'h0007, p3 = 16'h0009;
  logic [15:0] reg_rdata, t2c, t3c, acc, d;
  logic [15:0] duty[4] = '{16'h0000, 16'h0007, 16'h0009, 16'h0000};
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'd36;
  int win = 0, err_total = 0, compares = 0;
  oc_far_side far (.clk(clk), .rst_n(rst_n), .run(run), .period2(p2), .period3(p3),
    .fault_req(fault_req), .count2(t2c), .count3(t3c), .fault_a(fault_a), .fault_b(fault_b));
  output_compare_pwm_channel uut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer2_count(t2c), .timer2_period(p2), .timer3_count(t3c),
    .timer3_period(p3), .cpu_idle(cpu_idle), .fault_input_a(fault_a),
    .fault_input_b(fault_b), .compare_output_pin(pin), .compare_interrupt_flag(flag));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  // count high pin cycles over a window of n cycles
  task automatic meas(input int n, input logic [15:0] e);
    exp_q.push_back(e);
    acc = 16'h0000;
    win = n;
    wait (win == 0);
  endtask
  task automatic wait_cnt(input logic [15:0] k);
    for (int i = 0; i < 100 && t3c !== k; i++) @(posedge clk);
  endtask
  // monitor: read data the cycle after the strobe, pin windows
  always @(posedge clk) rd_v <= reg_read;
  always @(negedge clk) begin
    if (rd_v) check(reg_rdata, exp_q.pop_front());
    if (win > 0) begin
      acc = acc + 16'(pin);
      win = win - 1;
      if (win == 0) check(acc, exp_q.pop_front());
    end
  end
  initial forever #10 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    d = xs();
    wr(ADDR_PRIMARY, d);
    rd(ADDR_PRIMARY, d);
    wr(ADDR_CONTROL, 16'hFFFF);
    rd(ADDR_CONTROL, 16'h200F);
    wr(ADDR_CONTROL, 16'h0008);
    rd(3'h5, 16'h0000);
    wr(ADDR_PRIMARY, 16'h0005);
    wr(ADDR_SECONDARY, 16'h0006);
    run <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      wait_cnt(16'h0000);
      wr(ADDR_CONTROL, 16'(8 + m));
      meas(1, 16'(m == 2));
      wait_cnt(16'h0008);
      meas(1, 16'(m != 2));
      rd(ADDR_STATUS, 16'h0001);
      wr(ADDR_STATUS, 16'h0001);
      rd(ADDR_STATUS, 16'h0000);
    end
    wr(ADDR_PRIMARY, 16'h0003);
    for (int m = 5; m > 3; m--) begin
      wait_cnt(16'h0000);
      wr(ADDR_CONTROL, 16'(8 + m));
      meas(20, (m == 5) ? 16'h0006 : 16'h0003);
    end
    wr(ADDR_SECONDARY, 16'h0003);
    wr(ADDR_CONTROL, 16'(MODE_PWM));
    repeat (8) @(posedge clk);
    meas(8, 16'h0003);
    duty[3] = 16'h0001 + xs() % 16'h0006;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SECONDARY, duty[i]);
      repeat (16) @(posedge clk);
      meas(8, (duty[i] > 16'h0007) ? 16'h0008 : duty[i]);
      wr(ADDR_PRIMARY, 16'h0005);
      rd(ADDR_PRIMARY, duty[i]);
    end
    @(posedge clk) fault_req <= 2'h1;
    repeat (16) @(posedge clk);
    meas(8, duty[3]);
    wr(ADDR_CONTROL, 16'(MODE_PWM_FAULT));
    repeat (4) @(posedge clk);
    meas(8, 16'h0000);
    @(posedge clk) fault_req <= 2'h2;
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 16'h0017);
    wr(ADDR_CONTROL, 16'(MODE_PWM));
    rd(ADDR_CONTROL, 16'h0006);
    wr(ADDR_CONTROL, 16'(MODE_PWM_FAULT));
    repeat (16) @(posedge clk);
    meas(8, duty[3]);
    @(posedge clk) cpu_idle <= 1'b1;
    repeat (8) @(posedge clk);
    meas(8, duty[3]);
    wrap_up();
  end
endmodule
